/* core/lcpc_pcm_if.sv */
`default_nettype none
interface lcpc_pcm_if;
  logic        active;
  logic        port_b;
  logic        linear;
  logic [7:0]  slot;
  logic [15:0] sample;
  logic        tx_data;
  logic        tx_oe_a;
  logic        tx_oe_b;
  logic        busy;

  modport ctrl (output active, output port_b, output linear, output slot, output sample,
                input tx_data, input tx_oe_a, input tx_oe_b, input busy);
  modport eng  (input active, input port_b, input linear, input slot, input sample,
                output tx_data, output tx_oe_a, output tx_oe_b, output busy);
endinterface : lcpc_pcm_if
`default_nettype wire

/* core/lcpc_pcm_tx.sv */
`default_nettype none
module lcpc_pcm_tx (
  input  wire logic clk_i,        // Core clock
  input  wire logic rst_i,        // Synchronous reset, core or pin reset
  input  wire logic pcm_clk_i,    // PCM bit clock pin
  input  wire logic frame_pulse_i,// Frame start pin
  lcpc_pcm_if.eng   pcm           // Config in, transmit out
);
  typedef struct packed {
    logic                         pclk_d;
    logic [lcpc_pkg::BITCNT_W-1:0] cnt;
    logic                         busy;
    logic                         on_b;
    logic [3:0]                   rem;
    logic [15:0]                  shreg;
    logic [15:0]                  sample;
    logic                         data;
    logic                         oe_a;
    logic                         oe_b;
  } lcpc_tx_state_t;

  lcpc_tx_state_t s_reg;
  lcpc_tx_state_t s_next;
  logic [1:0]     sy;
  logic           pclk_edge;
  logic           fs;

  lcpc_sync #(.W(2), .RST_VAL(2'h0)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({frame_pulse_i, pcm_clk_i}),
    .q_o   (sy)
  );

  assign pclk_edge = sy[0] & ~s_reg.pclk_d;
  assign fs        = sy[1];

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [lcpc_pkg::BITCNT_W-1:0] cur;
    logic                          start;
    cur          = s_reg.cnt;
    start        = 1'b0;
    s_next       = s_reg;
    s_next.pclk_d = sy[0];
    if (pclk_edge)
    begin
      // Bit 0 of slot 0 is the edge that sees the frame pulse
      cur        = fs ? '0 : s_reg.cnt + {{(lcpc_pkg::BITCNT_W-1){1'b0}}, 1'b1};
      s_next.cnt = cur;
      if (fs)
      begin
        s_next.sample = pcm.sample;
      end
      if (s_reg.busy)
      begin
        if (s_reg.rem == 4'h0)
        begin
          s_next.busy = 1'b0;
        end
        else
        begin
          s_next.rem   = s_reg.rem - 4'h1;
          s_next.shreg = {s_reg.shreg[14:0], 1'b0};
        end
      end
      start = pcm.active && ({pcm.slot, 3'h0} == cur) && !s_next.busy;
      if (start)
      begin
        s_next.busy = 1'b1;
        s_next.on_b = pcm.port_b;
        // Companded form keeps the top byte; no law table here
        s_next.shreg = pcm.linear ? s_next.sample : {s_next.sample[15:8], 8'h00};
        s_next.rem   = pcm.linear ? lcpc_pkg::LAST_LIN : lcpc_pkg::LAST_COMP;
      end
    end
    if (!pcm.active)
    begin
      s_next.busy = 1'b0;
    end
    s_next.data = s_next.shreg[15];
    s_next.oe_a = s_next.busy & ~s_next.on_b;
    s_next.oe_b = s_next.busy & s_next.on_b;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign pcm.tx_data = s_reg.data;
  assign pcm.tx_oe_a = s_reg.oe_a;
  assign pcm.tx_oe_b = s_reg.oe_b;
  assign pcm.busy    = s_reg.busy;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence frame_start_s;
    pclk_edge && fs;
  endsequence

  frame_zero_a: assert property (frame_start_s |=> s_reg.cnt == '0)
    else $error("bit counter not cleared by frame pulse");
  ports_apart_a: assert property (!(s_reg.oe_a && s_reg.oe_b))
    else $error("both transmit ports driven");
  float_idle_a: assert property (!pcm.active |=> !s_reg.oe_a && !s_reg.oe_b)
    else $error("transmit port driven while inactive");
  msb_first_a: assert property (pclk_edge && s_reg.busy && s_reg.rem != 4'h0
                                |=> s_reg.data == $past(s_reg.shreg[14]))
    else $error("bit order wrong");
endmodule : lcpc_pcm_tx
`default_nettype wire

/* core/lcpc_pkg.sv */
`default_nettype none
package lcpc_pkg;
  // Register byte addresses, one aligned 32-bit word each
  localparam logic [7:0] ADR_CHAN_CTRL = 8'h00;
  localparam logic [7:0] ADR_GP_DIR    = 8'h04;
  localparam logic [7:0] ADR_GP_IN     = 8'h08;
  localparam logic [7:0] ADR_SIG_STAT  = 8'h0C;
  localparam logic [7:0] ADR_SIG_MASK  = 8'h10;
  localparam logic [7:0] ADR_INT_STAT  = 8'h14;
  localparam logic [7:0] ADR_CLK_CFG   = 8'h18;
  localparam logic [7:0] ADR_PCM_CFG   = 8'h1C;
  localparam logic [7:0] ADR_RESET_CMD = 8'h20;

  localparam int GP_W  = 4;
  localparam int SIG_W = 8;

  // Field positions
  localparam int INT_PEND_BIT  = 0;
  localparam int MCLK_EN_BIT   = 0;
  localparam int RESET_GO_BIT  = 0;
  localparam int PCM_PORT_B    = 8;
  localparam int PCM_LINEAR    = 9;
  localparam int PCM_ACTIVE    = 10;
  localparam int PCM_BUSY      = 11;

  // Reset values
  localparam logic [GP_W-1:0]  RST_CHAN_CTRL = 4'h0;
  localparam logic [GP_W-1:0]  RST_GP_DIR    = 4'h0;
  localparam logic [SIG_W-1:0] RST_SIG_MASK  = 8'h00;
  localparam logic             RST_MCLK_EN   = 1'b0;
  localparam logic [7:0]       RST_SLOT      = 8'h00;

  // Timing
  localparam int CLK_MHZ        = 20;
  localparam int RST_GLITCH_NS  = 100;
  localparam int RST_MIN_US     = 50;
  localparam int RST_GLITCH_CYC = (RST_GLITCH_NS * CLK_MHZ + 999) / 1000;
  // A pulse shorter than the glitch time covers at most RST_GLITCH_CYC samples
  localparam logic [2:0] RST_FILT_CYC = 3'(RST_GLITCH_CYC + 1);

  // PCM burst shape
  localparam int         BITCNT_W  = 11;
  localparam logic [3:0] LAST_COMP = 4'h7;
  localparam logic [3:0] LAST_LIN  = 4'hF;
endpackage : lcpc_pkg
`default_nettype wire

/* core/lcpc_sync.sv */
`default_nettype none
module lcpc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,  // Core clock
  input  wire logic         rst_i,  // Synchronous reset
  input  wire logic [W-1:0] d_i,    // Asynchronous levels
  output logic      [W-1:0] q_o     // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lcpc_sync_state_t;

  lcpc_sync_state_t s_reg;
  lcpc_sync_state_t s_next;

  always_comb
  begin
    s_next    = s_reg;
    s_next.s1 = d_i;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= {RST_VAL, RST_VAL};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.s2;
endmodule : lcpc_sync
`default_nettype wire

/* core/lcpc_top.sv */
// Overview of operation
// - Interrupt output goes low when a signaling bit changes.
// - Masked signaling bits never raise the interrupt.
// - Interrupt stays low until software clears it.
// - Each of four control ports is programmable input or output.
// - Output ports drive their bits of the channel control register.
// - After reset processing uses the PCM clock until software selects master clock.
// - PCM data shifts out at the PCM clock rate.
// - Low reset pin restores defaults, like the reset command.
// - Reset pin low pulses under 100 ns are ignored.
// - Slot indicator A or B active exactly while its port transmits.
// - Slot indicators are open drain, never driven high.
// - Voice input sample is sent in the transmit slot, whole (linear) or as its top byte.
// - Bursts of 8 or 16 bits MSB first; port floats otherwise.
`default_nettype none
module lcpc_top (
  input  wire logic        clk_i,                // 20 MHz core clock
  input  wire logic        rst_i,                // Synchronous reset, high
  input  wire logic        wb_cyc_i,             // Wishbone cycle
  input  wire logic        wb_stb_i,             // Wishbone strobe
  input  wire logic        wb_we_i,              // Wishbone write
  input  wire logic [7:0]  wb_adr_i,             // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,             // Wishbone byte enables
  input  wire logic [31:0] wb_dat_i,             // Wishbone write data
  output logic      [31:0] wb_dat_o,             // Wishbone read data
  output logic             wb_ack_o,             // Wishbone acknowledge
  input  wire logic        rst_pin_n_i,          // Reset pin, low active
  input  wire logic [7:0]  sig_bits_i,           // Line signaling bits
  output logic             int_n_o,              // Interrupt, low active
  input  wire logic [3:0]  gp_ctl_port_i,        // Control port levels
  output logic      [3:0]  gp_ctl_port_o,        // Control port drive value
  output logic      [3:0]  gp_ctl_port_oe_o,     // Control port drive enable
  output logic             proc_clk_mclk_o,      // Processing from master clock
  input  wire logic        pcm_clk_i,            // PCM bit clock pin
  input  wire logic        frame_pulse_i,        // Frame start pin
  input  wire logic [15:0] voice_analog_in_i,    // Digitised voice sample
  output logic             pcm_tx_a_o,           // Transmit port A data
  output logic             pcm_tx_a_oe_o,        // Transmit port A enable
  output logic             pcm_tx_b_o,           // Transmit port B data
  output logic             pcm_tx_b_oe_o,        // Transmit port B enable
  output logic             slot_active_a_n_o,    // Slot A indicator value
  output logic             slot_active_a_n_oe_o, // Slot A indicator enable
  output logic             slot_active_b_n_o,    // Slot B indicator value
  output logic             slot_active_b_n_oe_o  // Slot B indicator enable
);
  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [3:0]  chan_ctrl;
    logic [3:0]  gp_dir;
    logic [7:0]  sig_mask;
    logic [7:0]  sig_prev;
    logic        armed;
    logic        pend;
    logic        int_n;
    logic        mclk_en;
    logic [7:0]  slot;
    logic        port_b;
    logic        linear;
    logic        active;
    logic [2:0]  flt_cnt;
    logic        pin_rst;
    logic        soft_rst;
    logic        core_rst;
    logic        ind_lvl;
  } lcpc_top_state_t;

  localparam lcpc_top_state_t ST_RST = '{
    ack: 1'b0, rdat: 32'h0, chan_ctrl: lcpc_pkg::RST_CHAN_CTRL,
    gp_dir: lcpc_pkg::RST_GP_DIR, sig_mask: lcpc_pkg::RST_SIG_MASK,
    sig_prev: 8'h00, armed: 1'b0, pend: 1'b0, int_n: 1'b1,
    mclk_en: lcpc_pkg::RST_MCLK_EN, slot: lcpc_pkg::RST_SLOT, port_b: 1'b0,
    linear: 1'b0, active: 1'b0, flt_cnt: 3'h0, pin_rst: 1'b0,
    soft_rst: 1'b0, core_rst: 1'b0, ind_lvl: 1'b0};

  lcpc_top_state_t s_reg;
  lcpc_top_state_t s_next;
  logic            req;
  logic            wr;
  logic            rst_sy;
  logic [3:0]      gp_sy;
  logic [7:0]      sig_sy;
  logic [7:0]      unm_chg;
  logic            tx_rst;

  lcpc_pcm_if pcm ();

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the reset pin idles high
  lcpc_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (rst_pin_n_i),
    .q_o   (rst_sy)
  );

  lcpc_sync #(.W(12), .RST_VAL(12'h000)) u_in_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({sig_bits_i, gp_ctl_port_i}),
    .q_o   ({sig_sy, gp_sy})
  );

  ////////////////////////////////////////////////////////////////////////////////
  assign req     = wb_cyc_i & wb_stb_i & ~s_reg.ack;
  assign wr      = req & wb_we_i;
  // Arming skips the first compare, where the previous value is only a reset constant
  assign unm_chg = (sig_sy ^ s_reg.sig_prev) & ~s_reg.sig_mask & {8{s_reg.armed}};
  assign tx_rst  = rst_i | s_reg.core_rst;

  always_comb
  begin
    s_next       = s_reg;
    s_next.ack   = req;
    s_next.rdat  = 32'h0;
    s_next.armed = 1'b1;
    s_next.soft_rst = 1'b0;
    s_next.sig_prev = sig_sy;

    if (req && !wb_we_i)
    begin
      if (hit(wb_adr_i, lcpc_pkg::ADR_CHAN_CTRL))
        s_next.rdat = {28'h0, s_reg.chan_ctrl};
      else if (hit(wb_adr_i, lcpc_pkg::ADR_GP_DIR))
        s_next.rdat = {28'h0, s_reg.gp_dir};
      else if (hit(wb_adr_i, lcpc_pkg::ADR_GP_IN))
        s_next.rdat = {28'h0, gp_sy};
      else if (hit(wb_adr_i, lcpc_pkg::ADR_SIG_STAT))
        s_next.rdat = {24'h0, sig_sy};
      else if (hit(wb_adr_i, lcpc_pkg::ADR_SIG_MASK))
        s_next.rdat = {24'h0, s_reg.sig_mask};
      else if (hit(wb_adr_i, lcpc_pkg::ADR_INT_STAT))
        s_next.rdat[lcpc_pkg::INT_PEND_BIT] = s_reg.pend;
      else if (hit(wb_adr_i, lcpc_pkg::ADR_CLK_CFG))
        s_next.rdat[lcpc_pkg::MCLK_EN_BIT] = s_reg.mclk_en;
      else if (hit(wb_adr_i, lcpc_pkg::ADR_PCM_CFG))
      begin
        s_next.rdat[7:0]                  = s_reg.slot;
        s_next.rdat[lcpc_pkg::PCM_PORT_B] = s_reg.port_b;
        s_next.rdat[lcpc_pkg::PCM_LINEAR] = s_reg.linear;
        s_next.rdat[lcpc_pkg::PCM_ACTIVE] = s_reg.active;
        s_next.rdat[lcpc_pkg::PCM_BUSY]   = pcm.busy;
      end
    end

    if (wr && wb_sel_i[0])
    begin
      if (hit(wb_adr_i, lcpc_pkg::ADR_CHAN_CTRL))
        s_next.chan_ctrl = wb_dat_i[3:0];
      if (hit(wb_adr_i, lcpc_pkg::ADR_GP_DIR))
        s_next.gp_dir = wb_dat_i[3:0];
      if (hit(wb_adr_i, lcpc_pkg::ADR_SIG_MASK))
        s_next.sig_mask = wb_dat_i[7:0];
      if (hit(wb_adr_i, lcpc_pkg::ADR_INT_STAT) && wb_dat_i[lcpc_pkg::INT_PEND_BIT])
        s_next.pend = 1'b0;
      if (hit(wb_adr_i, lcpc_pkg::ADR_CLK_CFG))
        s_next.mclk_en = wb_dat_i[lcpc_pkg::MCLK_EN_BIT];
      if (hit(wb_adr_i, lcpc_pkg::ADR_PCM_CFG))
        s_next.slot = wb_dat_i[7:0];
      if (hit(wb_adr_i, lcpc_pkg::ADR_RESET_CMD))
        s_next.soft_rst = wb_dat_i[lcpc_pkg::RESET_GO_BIT];
    end
    if (wr && wb_sel_i[1] && hit(wb_adr_i, lcpc_pkg::ADR_PCM_CFG))
    begin
      s_next.port_b = wb_dat_i[lcpc_pkg::PCM_PORT_B];
      s_next.linear = wb_dat_i[lcpc_pkg::PCM_LINEAR];
      s_next.active = wb_dat_i[lcpc_pkg::PCM_ACTIVE];
    end

    // A change in the clearing cycle wins over the clear
    if (|unm_chg)
    begin
      s_next.pend = 1'b1;
    end

    // Glitch filter on the synchronised pin
    if (rst_sy)
      s_next.flt_cnt = 3'h0;
    else if (s_reg.flt_cnt != lcpc_pkg::RST_FILT_CYC)
      s_next.flt_cnt = s_reg.flt_cnt + 3'h1;
    s_next.pin_rst  = !rst_sy && (s_next.flt_cnt == lcpc_pkg::RST_FILT_CYC);
    s_next.core_rst = s_next.pin_rst | s_next.soft_rst;

    // Bus handshake is kept alive so a command reset still completes its cycle
    if (s_reg.core_rst)
    begin
      s_next.chan_ctrl = lcpc_pkg::RST_CHAN_CTRL;
      s_next.gp_dir    = lcpc_pkg::RST_GP_DIR;
      s_next.sig_mask  = lcpc_pkg::RST_SIG_MASK;
      s_next.armed     = 1'b0;
      s_next.pend      = 1'b0;
      s_next.mclk_en   = lcpc_pkg::RST_MCLK_EN;
      s_next.slot      = lcpc_pkg::RST_SLOT;
      s_next.port_b    = 1'b0;
      s_next.linear    = 1'b0;
      s_next.active    = 1'b0;
    end
    s_next.int_n   = ~s_next.pend;
    s_next.ind_lvl = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= ST_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign pcm.active = s_reg.active;
  assign pcm.port_b = s_reg.port_b;
  assign pcm.linear = s_reg.linear;
  assign pcm.slot   = s_reg.slot;
  assign pcm.sample = voice_analog_in_i;

  lcpc_pcm_tx u_tx (
    .clk_i         (clk_i),
    .rst_i         (tx_rst),
    .pcm_clk_i     (pcm_clk_i),
    .frame_pulse_i (frame_pulse_i),
    .pcm           (pcm.eng)
  );

  assign wb_dat_o             = s_reg.rdat;
  assign wb_ack_o             = s_reg.ack;
  assign int_n_o              = s_reg.int_n;
  assign gp_ctl_port_o        = s_reg.chan_ctrl;
  assign gp_ctl_port_oe_o     = s_reg.gp_dir;
  assign proc_clk_mclk_o      = s_reg.mclk_en;
  assign pcm_tx_a_o           = pcm.tx_data;
  assign pcm_tx_a_oe_o        = pcm.tx_oe_a;
  assign pcm_tx_b_o           = pcm.tx_data;
  assign pcm_tx_b_oe_o        = pcm.tx_oe_b;
  // Same flop as the data enable, so indicator and burst cannot skew
  assign slot_active_a_n_o    = s_reg.ind_lvl;
  assign slot_active_a_n_oe_o = pcm.tx_oe_a;
  assign slot_active_b_n_o    = s_reg.ind_lvl;
  assign slot_active_b_n_oe_o = pcm.tx_oe_b;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence rst_low3_s;
    !rst_sy [*3];
  endsequence

  sequence rst_glitch_s;
    rst_sy ##1 !rst_sy [*2] ##1 rst_sy;
  endsequence

  int_raise_a: assert property (|unm_chg && !s_reg.core_rst |=> !int_n_o)
    else $error("unmasked change did not raise interrupt");
  int_masked_a: assert property (!s_reg.pend && unm_chg == 8'h00 |=> int_n_o)
    else $error("interrupt without unmasked change");
  int_hold_a: assert property (!int_n_o && !(wr && wb_sel_i[0]
                               && hit(wb_adr_i, lcpc_pkg::ADR_INT_STAT))
                               && !s_reg.core_rst |=> !int_n_o)
    else $error("interrupt released without clear");
  gp_level_a: assert property (wr && wb_sel_i[0] && hit(wb_adr_i, lcpc_pkg::ADR_CHAN_CTRL)
                               && !s_reg.core_rst
                               |=> gp_ctl_port_o == $past(wb_dat_i[3:0]))
    else $error("control port level not taken");
  gp_dir_a: assert property (s_reg.core_rst |=> gp_ctl_port_oe_o == lcpc_pkg::RST_GP_DIR)
    else $error("control port direction not reset");
  mclk_sel_a: assert property ($rose(proc_clk_mclk_o) |-> $past(wr))
    else $error("master clock selected without a write");
  // Pin and core reset leave the filter together, so a released pin drops both at once
  rst_take_a: assert property (rst_low3_s |=> s_reg.pin_rst && s_reg.core_rst)
    else $error("held reset pin not taken");
  rst_glitch_a: assert property (rst_glitch_s |-> !s_reg.pin_rst)
    else $error("short reset pulse accepted");
  ind_low_a: assert property (slot_active_a_n_oe_o |-> !slot_active_a_n_o
                              && pcm_tx_a_oe_o)
    else $error("slot indicator A wrong");
endmodule : lcpc_top
`default_nettype wire

/* core/lcpc_unused_guard.sv */
`default_nettype none
`default_nettype wire

/* tb/lcpc_pcm_far.sv */
`default_nettype none
module lcpc_pcm_far #(
  parameter int FRAME_BITS = 32
) (
  output var logic pcm_clk_o,    // PCM bit clock
  output var logic frame_pulse_o // Frame start
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_n = 0;
  initial
  begin
    pcm_clk_o = 1'b0;
    frame_pulse_o = 1'b0;
    forever
    begin
      #200 pcm_clk_o = 1'b1;
      #200 pcm_clk_o = 1'b0;
      // Moved on the falling edge so it is steady at the rising one
      frame_pulse_o = (bit_n == 0);
      bit_n = (bit_n + 1) % FRAME_BITS;
    end
  end
endmodule // lcpc_pcm_far
`default_nettype wire

/* tb/lcpc_top_tb.sv */
`default_nettype none
module lcpc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rst_pin_n_i, int_n_o;
  logic        pcm_clk_i, frame_pulse_i, proc_clk_mclk_o, pcm_tx_a_o, pcm_tx_a_oe_o;
  logic        pcm_tx_b_o, pcm_tx_b_oe_o, slot_active_a_n_o, slot_active_a_n_oe_o;
  logic        slot_active_b_n_o, slot_active_b_n_oe_o;
  logic [7:0]  wb_adr_i, sig_bits_i;
  logic [3:0]  wb_sel_i, gp_ctl_port_i, gp_ctl_port_o, gp_ctl_port_oe_o, d, o, g;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] voice_analog_in_i, sh;
  logic [31:0] rd_q[$];
  logic [17:0] burst_q[$];
  int          n_fail = 0, tests_run = 0, cyc_n = 0, nb = 0;

  lcpc_top lcpc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rst_pin_n_i(rst_pin_n_i),
    .sig_bits_i(sig_bits_i), .int_n_o(int_n_o), .gp_ctl_port_i(gp_ctl_port_i),
    .gp_ctl_port_o(gp_ctl_port_o), .gp_ctl_port_oe_o(gp_ctl_port_oe_o),
    .proc_clk_mclk_o(proc_clk_mclk_o), .pcm_clk_i(pcm_clk_i), .frame_pulse_i(frame_pulse_i),
    .voice_analog_in_i(voice_analog_in_i), .pcm_tx_a_o(pcm_tx_a_o),
    .pcm_tx_a_oe_o(pcm_tx_a_oe_o), .pcm_tx_b_o(pcm_tx_b_o), .pcm_tx_b_oe_o(pcm_tx_b_oe_o),
    .slot_active_a_n_o(slot_active_a_n_o), .slot_active_a_n_oe_o(slot_active_a_n_oe_o),
    .slot_active_b_n_o(slot_active_b_n_o), .slot_active_b_n_oe_o(slot_active_b_n_oe_o));
  lcpc_pcm_far lcpc_pcm_far_i (.pcm_clk_o(pcm_clk_i), .frame_pulse_o(frame_pulse_i));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // For reads dat is the expected word, noted for the watcher
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    if (!we)
      rd_q.push_back(dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= we ? dat : 32'h0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (wb_ack_o === 1'b1 && !wb_we_i && rd_q.size() > 0)
      chk(wb_dat_o, rd_q.pop_front());
    if (cyc_n == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end

  // Burst collector: a bit is settled at the PCM edge after it is launched
  always @(posedge pcm_clk_i)
  begin
    chk(32'({slot_active_a_n_oe_o, slot_active_b_n_oe_o}), 32'({pcm_tx_a_oe_o, pcm_tx_b_oe_o}));
    chk(32'({slot_active_a_n_o, slot_active_b_n_o}), 32'h0);
    if (pcm_tx_a_oe_o === 1'b1 || pcm_tx_b_oe_o === 1'b1)
    begin
      if (burst_q.size() == 0)
        chk(32'h1, 32'h0);
      else
      begin
        chk(32'(pcm_tx_b_oe_o), 32'(burst_q[0][17]));
        sh = {sh[14:0], pcm_tx_a_oe_o ? pcm_tx_a_o : pcm_tx_b_o};
        nb++;
        if (nb == (burst_q[0][16] ? 16 : 8))
        begin
          chk(32'(sh), burst_q[0][16] ? 32'(burst_q[0][15:0]) : 32'(burst_q[0][15:8]));
          void'(burst_q.pop_front());
          nb = 0;
          sh = 16'h0;
        end
      end
    end
  end

  task automatic pcm_run(input logic b, input logic lin, input logic [7:0] slot);
    logic [15:0] v;
    v = 16'($urandom);
    voice_analog_in_i <= v;
    @(negedge frame_pulse_i);
    @(negedge frame_pulse_i);
    @(posedge clk_i);
    burst_q.push_back({b, lin, v});
    wb(1'b1, lcpc_pkg::ADR_PCM_CFG, {21'h0, 1'b1, lin, b, slot});
    while (burst_q.size() > 0)
      @(posedge clk_i);
    wb(1'b1, lcpc_pkg::ADR_PCM_CFG, 32'h0);
  endtask

  initial
  begin
    static logic [7:0] slots [4] = '{8'h01, 8'h03, 8'h00, 8'h02};
    static logic [7:0] adrs [5] = '{8'h00, 8'h04, 8'h10, 8'h18, 8'h3C};
    int k;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    rst_pin_n_i = 1'b1;
    sig_bits_i = 8'h00;
    gp_ctl_port_i = 4'h0;
    voice_analog_in_i = 16'h0;
    sh = 16'h0;
    void'($urandom(21));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(int_n_o), 32'h1);
    chk(32'(proc_clk_mclk_o), 32'h0);
    foreach (adrs[i])
      wb(1'b0, adrs[i], 32'h0);
    wb(1'b1, lcpc_pkg::ADR_CLK_CFG, 32'h1);
    chk(32'(proc_clk_mclk_o), 32'h1);
    d = 4'($urandom);
    o = 4'($urandom) | 4'h1;
    g = 4'($urandom);
    gp_ctl_port_i <= g;
    wb(1'b1, lcpc_pkg::ADR_GP_DIR, 32'(d));
    wb(1'b1, lcpc_pkg::ADR_CHAN_CTRL, 32'(o));
    chk(32'(gp_ctl_port_oe_o), 32'(d));
    chk(32'(gp_ctl_port_o), 32'(o));
    wb(1'b0, lcpc_pkg::ADR_GP_IN, 32'(g));
    wb(1'b1, lcpc_pkg::ADR_SIG_MASK, 32'h1);
    k = 1 + $urandom % 7;
    sig_bits_i <= 8'h01;
    repeat (6) @(posedge clk_i);
    chk(32'(int_n_o), 32'h1);
    sig_bits_i <= 8'h01 | (8'h01 << k);
    repeat (6) @(posedge clk_i);
    chk(32'(int_n_o), 32'h0);
    sig_bits_i <= 8'h01;
    repeat (6) @(posedge clk_i);
    chk(32'(int_n_o), 32'h0);
    wb(1'b0, lcpc_pkg::ADR_SIG_STAT, 32'h1);
    wb(1'b0, lcpc_pkg::ADR_INT_STAT, 32'h1);
    wb(1'b1, lcpc_pkg::ADR_INT_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(32'(int_n_o), 32'h1);
    // Two samples low is the longest pulse the filter must still ignore
    rst_pin_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_pin_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    wb(1'b0, lcpc_pkg::ADR_CHAN_CTRL, 32'(o));
    rst_pin_n_i <= 1'b0;
    repeat (1000) @(posedge clk_i);
    rst_pin_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    wb(1'b0, lcpc_pkg::ADR_CHAN_CTRL, 32'h0);
    chk(32'({gp_ctl_port_oe_o, proc_clk_mclk_o}), 32'h0);
    wb(1'b1, lcpc_pkg::ADR_CHAN_CTRL, 32'(o));
    wb(1'b1, lcpc_pkg::ADR_RESET_CMD, 32'h1);
    repeat (4) @(posedge clk_i);
    wb(1'b0, lcpc_pkg::ADR_CHAN_CTRL, 32'h0);
    for (int i = 0; i < 4; i++)
      pcm_run(i[0], i[1], slots[i]);
    stop_test();
  end
endmodule // lcpc_top_tb
`default_nettype wire
